// [logic/tlo_pkg.sv]
// Package with opcodes, field positions and register map of the table and logic decoder
package tlo_pkg;
    // Opcode match values and field positions
    localparam logic [5:0]  OP6_SWAP     = 6'h0E;
    localparam logic [5:0]  OP6_XORF     = 6'h06;
    localparam logic [5:0]  OP6_SUBB     = 6'h16;
    localparam logic [6:0]  OP7_TSTZ     = 7'h33;
    localparam logic [7:0]  OP8_XORL     = 8'h0A;
    localparam logic [11:0] OP12_TBL     = 12'h000;
    localparam logic [1:0]  TBL_RD_SEL   = 2'h2;
    localparam logic [1:0]  TBL_WT_SEL   = 2'h3;
    localparam logic [1:0]  MODE_NONE    = 2'h0;
    localparam logic [1:0]  MODE_POSTINC = 2'h1;
    localparam logic [1:0]  MODE_POSTDEC = 2'h2;
    localparam logic [1:0]  MODE_PREINC  = 2'h3;
    localparam logic [7:0]  IDX_LIMIT    = 8'h5F;
    localparam int          PTR_W        = 21;
    localparam int          HOLD_AW      = 6;
    localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
    // Status flag bit positions
    localparam int          FL_C         = 0;
    localparam int          FL_DC        = 1;
    localparam int          FL_Z         = 2;
    localparam int          FL_OV        = 3;
    localparam int          FL_N         = 4;
    // Register map, byte addresses on the bus
    localparam logic [7:0]  ADR_INSTR    = 8'h00;
    localparam logic [7:0]  ADR_FILE     = 8'h04;
    localparam logic [7:0]  ADR_WREG     = 8'h08;
    localparam logic [7:0]  ADR_STATUS   = 8'h0C;
    localparam logic [7:0]  ADR_PTR      = 8'h10;
    localparam logic [7:0]  ADR_LATCH    = 8'h14;
    localparam logic [7:0]  ADR_RESULT   = 8'h18;
    localparam logic [7:0]  ADR_CTRL     = 8'h1C;
    localparam logic [7:0]  ADR_HOLD     = 8'h20;
    localparam logic [7:0]  ADR_PMDATA   = 8'h24;
    // Result and control word field positions, bus transfer and skip codes
    localparam int          RS_DEST      = 8;
    localparam int          RS_SKIP      = 9;
    localparam int          RS_WFILE     = 10;
    localparam int          RS_ADDR      = 12;
    localparam int          CT_XINST     = 0;
    localparam int          CT_BSR       = 8;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic [1:0]  SKIP_ONE     = 2'h1;
    localparam logic [1:0]  SKIP_TWO     = 2'h2;
    typedef enum {ST_IDLE, ST_TBL2, ST_SKIP} tlo_state_t;
endpackage

// [logic/tlo_alu.sv]
`timescale 1ns/100ps
// Combinational ALU for nibble swap, exclusive-OR and subtract with borrow
module tlo_alu
    import tlo_pkg::*;
(
    input  wire logic [1:0] op,
    input  wire logic [7:0] wreg,
    input  wire logic [7:0] fval,
    input  wire logic [7:0] lit,
    input  wire logic [4:0] flags_in,
    output logic      [7:0] res,
    output logic      [4:0] flags_out
);
    logic [8:0] diff;
    logic [4:0] ldiff;

    // op 0 swap, 1 xor file, 2 xor literal, 3 subtract with borrow
    always_comb
    begin
        diff      = {1'b0, fval} - {1'b0, wreg} - {8'h00, ~flags_in[FL_C]};
        ldiff     = {1'b0, fval[3:0]} - {1'b0, wreg[3:0]} - {4'h0, ~flags_in[FL_C]};
        flags_out = flags_in;
        res       = 8'h00;
        case (op)
            2'h0:
            begin
                res = {fval[3:0], fval[7:4]};          // [RL1]
            end
            2'h1, 2'h2:
            begin
                res = wreg ^ ((op == 2'h1) ? fval : lit); // [RL11] [RL12]
                flags_out[FL_N] = res[7];
                flags_out[FL_Z] = (res == 8'h00);
            end
            default:
            begin
                res = diff[7:0];                        // [RL13]
                flags_out[FL_N]  = res[7];
                flags_out[FL_Z]  = (res == 8'h00);
                flags_out[FL_C]  = ~diff[8];            // Carry cleared on borrow
                flags_out[FL_DC] = ~ldiff[4];
                flags_out[FL_OV] = (fval[7] != wreg[7]) && (res[7] != fval[7]);
            end
        endcase
    end
endmodule

// [logic/tlo_core.sv]
`timescale 1ns/100ps
// Decode and execute of table access and logic instructions, with AHB-Lite register port
// Notes on behaviour
// RL1: Nibble swap writes the source byte with its two halves exchanged and leaves flags alone.
// RL2: A destination bit of 0 sends the result to W, 1 sends it back to the file register.
// RL3: Access bit 0 uses the access bank, 1 uses the bank select register for the bank.
// RL4: Access bit 0 with extended set on and operand up to 95 means indexed literal offset.
// RL5: A 21-bit table pointer addresses program memory bytewise over 2 Mbyte.
// RL6: Pointer bit 0 picks the low byte (0) or high byte (1) of a program word.
// RL7: Low bits 10nn are table read, 11nn table write, nn picks none, post-inc, post-dec, pre-inc.
// RL8: Post modes access then step by one, pre-increment steps first then accesses.
// RL9: Table write copies the latch into the holding register picked by the pointer, no programming.
// RL10: Test-zero-skip discards the prefetched instruction for a no-op when the file reads zero.
// RL11: Exclusive-OR literal updates W with W xor literal and only N and Z.
// RL12: Exclusive-OR file routes W xor file by the destination bit and only N and Z change.
// RL13: Subtract with borrow computes file minus W minus inverted carry with all five flags.
// RL14: Table read and write take two cycles, the second does the memory work only.
// RL15: A taken skip over a two or three word instruction spends one no-op cycle per word after the first.
module tlo_core
    import tlo_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [20:0] pm_addr,
    output logic             pm_rd,
    input  wire logic [7:0]  pm_rdata
);
    import tlo_pkg::*;

    logic [15:0]      instr_ff, nxt_instr;
    logic [7:0]       file_ff, nxt_file;
    logic [7:0]       wreg_ff, nxt_wreg;
    logic [4:0]       stat_ff, nxt_stat;
    logic [PTR_W-1:0] ptr_ff, nxt_ptr;
    logic [7:0]       latch_ff, nxt_latch;
    logic [31:0]      result_ff, nxt_result;
    logic [11:0]      ctrl_ff, nxt_ctrl;
    logic [1:0]       skipw_ff, nxt_skipw;
    logic             busy_ff, nxt_busy;
    logic             tbl_wr_ff, nxt_tbl_wr;
    logic [7:0]       hold_ff [2**HOLD_AW];
    logic [7:0]       nxt_hold [2**HOLD_AW];
    tlo_state_t       state_ff, nxt_state;
    logic             wph_ff, nxt_wph;
    logic [7:0]       aph_ff, nxt_aph;
    logic [31:0]      rdat_ff, nxt_rdat;

    logic             go;
    logic             is_swap, is_xorf, is_subb, is_tstz, is_xorl, is_trd, is_twt;
    logic [1:0]       alu_op;
    logic [7:0]       alu_res;
    logic [4:0]       alu_flags;
    logic [PTR_W-1:0] acc_ptr;
    logic [11:0]      eff_addr;
    logic             ahb_wr;

    // Opcode decode of the instruction latched from software
    assign is_swap = (instr_ff[15:10] == OP6_SWAP);
    assign is_xorf = (instr_ff[15:10] == OP6_XORF);
    assign is_subb = (instr_ff[15:10] == OP6_SUBB);
    assign is_tstz = (instr_ff[15:9] == OP7_TSTZ);
    assign is_xorl = (instr_ff[15:8] == OP8_XORL);
    assign is_trd  = (instr_ff[15:4] == OP12_TBL) && (instr_ff[3:2] == TBL_RD_SEL); // [RL7]
    assign is_twt  = (instr_ff[15:4] == OP12_TBL) && (instr_ff[3:2] == TBL_WT_SEL); // [RL7]
    assign alu_op  = is_swap ? 2'h0 : is_xorf ? 2'h1 : is_xorl ? 2'h2 : 2'h3;

    // Pre-increment steps before the access, all other modes access at the current pointer
    assign acc_ptr = (instr_ff[1:0] == MODE_PREINC) ? ptr_ff + PTR_ONE : ptr_ff; // [RL8]

    // Bank forming: access bank low half maps to bank 0, high half to bank F
    always_comb
    begin
        if (instr_ff[8])
            eff_addr = {ctrl_ff[CT_BSR+3:CT_BSR], instr_ff[7:0]};  // [RL3]
        else
            eff_addr = {(instr_ff[7] ? 4'hF : 4'h0), instr_ff[7:0]}; // [RL3]
    end

    tlo_alu u_alu
    (
        .op        (alu_op),
        .wreg      (wreg_ff),
        .fval      (file_ff),
        .lit       (instr_ff[7:0]),
        .flags_in  (stat_ff),
        .res       (alu_res),
        .flags_out (alu_flags)
    );

    // Bus address phase capture; single-cycle answers so hreadyout stays high
    assign ahb_wr    = wph_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdat_ff;
    assign pm_addr   = acc_ptr;
    assign pm_rd     = (state_ff == ST_TBL2) && (skipw_ff == 2'h0) && !tbl_wr_ff; // [RL14]

    always_comb
    begin
        nxt_wph = hsel && hready && (htrans == HTRANS_NSEQ) && hwrite;
        nxt_aph = (hsel && hready && (htrans == HTRANS_NSEQ)) ? haddr[7:0] : aph_ff;
        nxt_rdat = 32'h0000_0000;
        // Taken at the address phase from next-state values, so it stands in the data phase and is current
        if (hsel && hready && (htrans == HTRANS_NSEQ) && !hwrite)
        begin
            case (haddr[7:0])
                ADR_INSTR:  nxt_rdat = {16'h0000, nxt_instr};
                ADR_FILE:   nxt_rdat = {24'h000000, nxt_file};
                ADR_WREG:   nxt_rdat = {24'h000000, nxt_wreg};
                ADR_STATUS: nxt_rdat = {26'h0000000, nxt_busy, nxt_stat};
                ADR_PTR:    nxt_rdat = {11'h000, nxt_ptr};
                ADR_LATCH:  nxt_rdat = {24'h000000, nxt_latch};
                ADR_RESULT: nxt_rdat = nxt_result;
                ADR_CTRL:   nxt_rdat = {20'h00000, nxt_ctrl};
                ADR_HOLD:   nxt_rdat = {24'h000000, nxt_hold[nxt_ptr[HOLD_AW-1:0]]};
                default:    nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    // Execute state machine, register writes and instruction effects
    always_comb
    begin
        nxt_instr  = instr_ff;
        nxt_file   = file_ff;
        nxt_wreg   = wreg_ff;
        nxt_stat   = stat_ff;
        nxt_ptr    = ptr_ff;
        nxt_latch  = latch_ff;
        nxt_result = result_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_skipw  = skipw_ff;
        nxt_busy   = busy_ff;
        nxt_tbl_wr = tbl_wr_ff;
        nxt_state  = state_ff;
        nxt_hold   = hold_ff;
        go         = 1'b0;
        if (ahb_wr && !busy_ff)
        begin
            case (aph_ff)
                ADR_INSTR:  begin nxt_instr = hwdata[15:0]; go = 1'b1; end
                ADR_FILE:   nxt_file  = hwdata[7:0];
                ADR_WREG:   nxt_wreg  = hwdata[7:0];
                ADR_STATUS: nxt_stat  = hwdata[4:0];
                ADR_PTR:    nxt_ptr   = hwdata[PTR_W-1:0]; // [RL5]
                ADR_LATCH:  nxt_latch = hwdata[7:0];
                ADR_CTRL:   nxt_ctrl  = hwdata[11:0];
                default:    nxt_ctrl  = ctrl_ff;
            endcase
        end
        case (state_ff)
            ST_IDLE:
            begin
                if (go)
                begin
                    nxt_busy  = 1'b1;
                    nxt_state = ST_SKIP;
                end
            end
            ST_SKIP:
            begin
                // First cycle of the instruction: decode and execute
                nxt_result = 32'h0000_0000;
                nxt_result[RS_ADDR+11:RS_ADDR] = eff_addr;
                nxt_result[RS_WFILE+1] = !instr_ff[8] && ctrl_ff[CT_XINST]
                                         && (instr_ff[7:0] <= IDX_LIMIT); // [RL4]
                nxt_state = ST_IDLE;
                nxt_busy  = 1'b0;
                if (is_swap || is_xorf || is_subb)
                begin
                    nxt_result[7:0] = alu_res;
                    nxt_result[RS_DEST] = instr_ff[9];
                    if (instr_ff[9])
                    begin
                        nxt_file = alu_res;                    // [RL2]
                        nxt_result[RS_WFILE] = 1'b1;
                    end
                    else
                        nxt_wreg = alu_res;                    // [RL2]
                    nxt_stat = alu_flags;                      // [RL1] [RL12] [RL13]
                end
                else if (is_xorl)
                begin
                    nxt_wreg = alu_res;                        // [RL11]
                    nxt_stat = alu_flags;
                    nxt_result[7:0] = alu_res;
                end
                else if (is_tstz)
                begin
                    nxt_result[RS_SKIP] = (file_ff == 8'h00);  // [RL10]
                    if (file_ff == 8'h00 && ctrl_ff[CT_XINST+1])
                    begin
                        nxt_skipw = ctrl_ff[CT_XINST+2] ? SKIP_TWO : SKIP_ONE; // [RL15]
                        nxt_state = ST_TBL2;
                        nxt_busy  = 1'b1;
                    end
                end
                else if (is_trd || is_twt)
                begin
                    nxt_tbl_wr = is_twt;
                    nxt_skipw  = 2'h0;
                    nxt_state  = ST_TBL2;                      // [RL14]
                    nxt_busy   = 1'b1;
                end
            end
            ST_TBL2:
            begin
                if (skipw_ff != 2'h0)
                begin
                    // No-op cycles for the extra words of a skipped instruction
                    nxt_skipw = skipw_ff - SKIP_ONE;           // [RL15]
                    if (skipw_ff == SKIP_ONE)
                    begin
                        nxt_state = ST_IDLE;
                        nxt_busy  = 1'b0;
                    end
                end
                else
                begin
                    if (tbl_wr_ff)
                        nxt_hold[acc_ptr[HOLD_AW-1:0]] = latch_ff; // [RL9] [RL6]
                    else
                        nxt_latch = pm_rdata;                  // [RL6]
                    case (instr_ff[1:0])
                        MODE_POSTINC: nxt_ptr = ptr_ff + PTR_ONE; // [RL8]
                        MODE_POSTDEC: nxt_ptr = ptr_ff - PTR_ONE; // [RL8]
                        MODE_PREINC:  nxt_ptr = acc_ptr;          // [RL8]
                        default:      nxt_ptr = ptr_ff;
                    endcase
                    nxt_state = ST_IDLE;
                    nxt_busy  = 1'b0;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    // Registers; the holding array also clears at reset so reads are defined
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            instr_ff  <= 16'h0000;
            file_ff   <= 8'h00;
            wreg_ff   <= 8'h00;
            stat_ff   <= 5'h00;
            ptr_ff    <= 21'h000000;
            latch_ff  <= 8'h00;
            result_ff <= 32'h0000_0000;
            ctrl_ff   <= 12'h000;
            skipw_ff  <= 2'h0;
            busy_ff   <= 1'b0;
            tbl_wr_ff <= 1'b0;
            state_ff  <= ST_IDLE;
            wph_ff    <= 1'b0;
            aph_ff    <= 8'h00;
            rdat_ff   <= 32'h0000_0000;
            hold_ff   <= '{default: 8'h00};
        end
        else
        begin
            instr_ff  <= nxt_instr;
            file_ff   <= nxt_file;
            wreg_ff   <= nxt_wreg;
            stat_ff   <= nxt_stat;
            ptr_ff    <= nxt_ptr;
            latch_ff  <= nxt_latch;
            result_ff <= nxt_result;
            ctrl_ff   <= nxt_ctrl;
            skipw_ff  <= nxt_skipw;
            busy_ff   <= nxt_busy;
            tbl_wr_ff <= nxt_tbl_wr;
            state_ff  <= nxt_state;
            wph_ff    <= nxt_wph;
            aph_ff    <= nxt_aph;
            rdat_ff   <= nxt_rdat;
            hold_ff   <= nxt_hold;
        end
    end

    // Within a table access the pointer moves only in the memory cycle
    a_ptr_steady: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_SKIP && is_trd && !ahb_wr) |=> (ptr_ff == $past(ptr_ff))) // [RL14]
        else $error("pointer moved in first table cycle");
    a_postinc_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_TBL2 && skipw_ff == 2'h0 && instr_ff[1:0] == MODE_POSTINC)
        |=> (ptr_ff == $past(ptr_ff) + PTR_ONE)) // [RL8]
        else $error("post-increment step wrong");
    a_postdec_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_TBL2 && skipw_ff == 2'h0 && instr_ff[1:0] == MODE_POSTDEC)
        |=> (ptr_ff == $past(ptr_ff) - PTR_ONE)) // [RL8]
        else $error("post-decrement step wrong");
    a_read_latch: assert property (@(posedge hclk) disable iff (!hresetn)
        pm_rd |=> (latch_ff == $past(pm_rdata))) // [RL14]
        else $error("table read did not load latch");
    a_swap_file: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_SKIP && is_swap && instr_ff[9] && !ahb_wr)
        |=> (file_ff == {$past(file_ff[3:0]), $past(file_ff[7:4])}) && $stable(stat_ff)) // [RL1]
        else $error("swap result wrong");
    a_xorl_wreg: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_SKIP && is_xorl && !ahb_wr)
        |=> (wreg_ff == ($past(wreg_ff) ^ $past(instr_ff[7:0])))) // [RL11]
        else $error("xor literal wrong");
    a_xorf_dest: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_SKIP && is_xorf && !instr_ff[9] && !ahb_wr) |=> $stable(file_ff)) // [RL2]
        else $error("xor to W touched file");
    a_skip_len: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_SKIP && is_tstz && file_ff != 8'h00) |=> (state_ff == ST_IDLE)) // [RL10]
        else $error("non-zero test did not finish at once");
    a_skip_words: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_SKIP && is_tstz && file_ff == 8'h00 && ctrl_ff[CT_XINST+1] && ctrl_ff[CT_XINST+2])
        |=> (state_ff == ST_TBL2) ##1 (state_ff == ST_TBL2) ##1 (state_ff == ST_IDLE)) // [RL15]
        else $error("skip over three words took wrong time");
endmodule

// [tb/tlo_pmem.sv]
// Program memory read port model for the table decoder bench
`timescale 1ns/100ps
module tlo_pmem
(
    input  wire logic        hclk,
    input  wire logic [20:0] pm_addr,
    input  wire logic        pm_rd,
    output logic      [7:0]  pm_rdata
);
    logic [7:0] word_byte;
    logic [7:0] last_ff = 8'hA5;

    // One byte per byte address over the whole 21-bit space, bit 0 picks the word half
    assign word_byte = pm_addr[7:0] ^ pm_addr[15:8] ^ {3'h0, pm_addr[20:16]};
    // A released port shows the inverse of the last byte, so a stale sample is caught
    assign pm_rdata = (pm_rd === 1'b1) ? word_byte : ~last_ff;

    // Remember the last byte handed out
    always @(posedge hclk)
    begin
        if (pm_rd === 1'b1)
        begin
            last_ff <= word_byte;
        end
    end
endmodule

// [tb/tlo_core_tb_top.sv]
// Self-checking bench for the table access and logic decoder
`timescale 1ns/100ps
module tlo_core_tb_top;
    import tlo_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [20:0] pm_addr;
    logic        pm_rd;
    logic [7:0]  pm_rdata;
    logic [20:0] rd_addr;
    logic [31:0] rv;
    int          rd_count = 0;
    int          err_count = 0;
    int          checked = 0;

    always #5 hclk = ~hclk;

    // The single slave's ready is the bus ready
    tlo_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));
    tlo_pmem PM (.hclk(hclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));

    // Count memory read cycles and keep the address of the last one
    always @(posedge hclk)
    begin
        if (pm_rd === 1'b1)
        begin
            rd_count <= rd_count + 1;
            rd_addr <= pm_addr;
        end
    end

    function automatic logic [7:0] pm_byte(input logic [20:0] a);
        return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
    endfunction

    task automatic results();
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            chk("hready", 32'h1, {31'h0, hreadyout});
            results();
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask

    // Start an instruction and poll busy, with a bound
    task automatic exec(input logic [15:0] ins);
        int n;
        wr(ADR_INSTR, {16'h0, ins});
        n = 0;
        do
        begin
            rd(ADR_STATUS, rv);
            n++;
        end
        while (rv[5] !== 1'b0 && n < 20);
        if (rv[5] !== 1'b0)
        begin
            chk("busy", 32'h0, {31'h0, rv[5]});
            results();
        end
    endtask

    task automatic setup(input logic [7:0] f, input logic [7:0] w, input logic [4:0] s);
        wr(ADR_FILE, {24'h0, f});
        wr(ADR_WREG, {24'h0, w});
        wr(ADR_STATUS, {27'h0, s});
    endtask

    task automatic look(input logic [7:0] f, input logic [7:0] w, input logic [4:0] s);
        rd(ADR_FILE, rv);
        chk("file", {24'h0, f}, rv);
        rd(ADR_WREG, rv);
        chk("wreg", {24'h0, w}, rv);
        rd(ADR_STATUS, rv);
        chk("flags", {27'h0, s}, {27'h0, rv[4:0]});
    endtask

    // Swap to file through the banked address, then to W through the access bank
    task automatic t_swap();
        setup(8'h53, 8'h00, 5'h1F);
        wr(ADR_CTRL, 32'h500);
        exec(16'h3B10);
        look(8'h35, 8'h00, 5'h1F);
        rd(ADR_RESULT, rv);
        chk("bank addr", 32'h510, {20'h0, rv[23:12]});
        chk("dest", 32'h1, {31'h0, rv[RS_DEST]});
        exec(16'h3890);
        look(8'h35, 8'h53, 5'h1F);
        rd(ADR_RESULT, rv);
        chk("access addr", 32'hF90, {20'h0, rv[23:12]});
        chk("dest", 32'h0, {31'h0, rv[RS_DEST]});
    endtask

    // Exclusive-OR with literal and with file, other flags must survive
    task automatic t_xor();
        setup(8'hAF, 8'hB5, 5'h0B);
        exec(16'h0AAF);
        look(8'hAF, 8'h1A, 5'h0B);
        exec(16'h0A1A);
        look(8'hAF, 8'h00, 5'h0F);
        setup(8'hAF, 8'hB5, 5'h10);
        exec(16'h1A10);
        look(8'h1A, 8'hB5, 5'h00);
        exec(16'h1810);
        look(8'h1A, 8'hAF, 5'h10);
    endtask

    // Subtract with borrow: positive, zero and negative results
    task automatic t_sub();
        setup(8'h19, 8'h0D, 5'h01);
        exec(16'h5A10);
        look(8'h0C, 8'h0D, 5'h01);
        setup(8'h1B, 8'h1A, 5'h00);
        exec(16'h5810);
        look(8'h1B, 8'h00, 5'h07);
        setup(8'h03, 8'h0E, 5'h01);
        exec(16'h5A10);
        look(8'hF5, 8'h0E, 5'h10);
    endtask

    // Test for zero: skip only on a zero file value, flags untouched
    task automatic t_skip();
        logic [7:0] v [3];
        v = '{8'h00, 8'h01, 8'h80};
        for (int i = 0; i < 3; i++)
        begin
            setup(v[i], 8'h12, 5'h15);
            exec(16'h6610);
            rd(ADR_RESULT, rv);
            chk("skip", {31'h0, v[i] == 8'h00}, {31'h0, rv[RS_SKIP]});
            look(v[i], 8'h12, 5'h15);
        end
    endtask

    // Extended set: indexed operand flag, then a zero skip over a three-word instruction
    task automatic t_ext();
        int c0;
        setup(8'h5F, 8'h00, 5'h00);
        wr(ADR_CTRL, 32'h507);
        exec(16'h185F);
        rd(ADR_RESULT, rv);
        chk("indexed", 32'h1, {31'h0, rv[RS_WFILE+1]});
        exec(16'h1860);
        rd(ADR_RESULT, rv);
        chk("direct", 32'h0, {31'h0, rv[RS_WFILE+1]});
        wr(ADR_FILE, 32'h0);
        c0 = rd_count;
        exec(16'h6610);
        rd(ADR_RESULT, rv);
        chk("long skip", 32'h1, {31'h0, rv[RS_SKIP]});
        chk("skip reads", 32'h0, rd_count - c0);
        wr(ADR_CTRL, 32'h500);
    endtask

    // All four pointer modes for read and write, with wrap at both ends
    task automatic t_table();
        logic [20:0] st [4];
        logic [20:0] nx;
        logic [20:0] ac;
        int          c0;
        st = '{21'h00A356, 21'h01A357, 21'h000000, 21'h1FFFFF};
        for (int m = 0; m < 4; m++)
        begin
            nx = (m == 1 || m == 3) ? st[m] + 21'h1 : (m == 2) ? st[m] - 21'h1 : st[m];
            ac = (m == 3) ? nx : st[m];
            wr(ADR_PTR, {11'h0, st[m]});
            c0 = rd_count;
            exec(16'h0008 | 16'(m));
            rd(ADR_PTR, rv);
            chk("read ptr", {11'h0, nx}, rv);
            chk("read addr", {11'h0, ac}, {11'h0, rd_addr});
            chk("read cycles", 32'h1, rd_count - c0);
            rd(ADR_LATCH, rv);
            chk("latch", {24'h0, pm_byte(ac)}, rv);
            wr(ADR_LATCH, 32'h30 + m);
            wr(ADR_PTR, {11'h0, st[m]});
            c0 = rd_count;
            exec(16'h000C | 16'(m));
            rd(ADR_PTR, rv);
            chk("write ptr", {11'h0, nx}, rv);
            chk("write reads", 32'h0, rd_count - c0);
            wr(ADR_PTR, {11'h0, ac});
            rd(ADR_HOLD, rv);
            chk("hold", 32'h30 + m, rv);
        end
    endtask

    // Reset, register sanity, then each scenario in turn
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADR_STATUS, rv);
        chk("status reset", 32'h0, rv);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, rv);
        chk("unmapped", 32'h0, rv);
        t_swap();
        t_xor();
        t_sub();
        t_skip();
        t_ext();
        t_table();
        results();
    end
endmodule
